/* common/reset_timer_map.svh */
// Timing constants and configuration codes of the long-press reset timer.
`ifndef RESET_TIMER_MAP_SVH
`define RESET_TIMER_MAP_SVH
`define CLK_MHZ 100
`define TICK_US 100
`define TICK_CYCLES (`TICK_US * `CLK_MHZ)
`define CNT_W 17
`define DLY_7P5_US 7500000
`define DLY_11P25_US 11250000
`define DLY_10_US 10000000
`define DLY_3P0_US 3000000
`define REL_0P234_US 234000
`define REL_0P313_US 313000
`define REL_0P078_US 78000
`define REL_0P1875_US 187500
`define TICKS(us) ((us) / `TICK_US)
`define CFG_7P5_234 2'h0
`define CFG_10_313 2'h1
`define CFG_10_078 2'h2
`define CFG_3P0_1875 2'h3
`endif

/* common/reset_timer_pkg.sv */
// Types shared by the long-press reset timer design.
`include "reset_timer_map.svh"
package reset_timer_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_COUNT = 2'b01,
        ST_ASSERT = 2'b10,
        ST_LOCKOUT = 2'b11
    } state_t;

    typedef struct packed {
        logic a_n;
        logic b_n;
    } trig_t;

    typedef struct packed {
        logic [`CNT_W-1:0] delay;
        logic [`CNT_W-1:0] release_t;
    } timing_t;
endpackage : reset_timer_pkg

/* test/key_host_model.sv */
// Behavioural model of the user keys, the board strap and the host reset receiver.
`timescale 1ns/1ns
module key_host_model (
    // Clock
    input wire logic sys_clk,
    // Commands from the bench
    input wire logic press_a,
    input wire logic press_b,
    input wire logic press_single,
    input wire logic strap_level,
    // Lines toward the timers
    output reset_timer_pkg::trig_t keys,
    output reset_timer_pkg::trig_t single_keys,
    output logic delay_sel,
    output logic delay_sel_hi,
    // Host reset receiver
    input wire logic host_rst_n,
    output logic [31:0] pulse_len
);
    logic [31:0] low_cnt;
    assign keys = '{a_n: ~press_a, b_n: ~press_b};
    // A one-key board grounds the unused key input.
    assign single_keys = '{a_n: ~press_single, b_n: 1'b0};
    // The strap is a board wire, so it never moves once the timer runs.
    assign delay_sel = strap_level;
    // A second board has its strap wired to the opposite level.
    assign delay_sel_hi = ~strap_level;
    initial begin
        low_cnt = 32'h0;
        pulse_len = 32'h0;
    end
    always @(posedge sys_clk) begin
        if (host_rst_n === 1'b0) begin
            low_cnt <= low_cnt + 32'h1;
        end else if (low_cnt != 32'h0) begin
            pulse_len <= low_cnt;
            low_cnt <= 32'h0;
        end
    end
endmodule : key_host_model

/* test/long_press_reset_timer_tb.sv */
// Self-checking bench for the long-press reset timer in strap, fixed and one-key use.
`timescale 1ns/1ns
`include "reset_timer_map.svh"
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin fail_count++; \
    $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); end end
module long_press_reset_timer_tb;
    // One cycle per tick keeps the longest count near 75000 cycles.
    localparam int unsigned TICK = 1;
    localparam int DLY_FIX = `TICKS(`DLY_3P0_US) * TICK;
    localparam int REL_FIX = `TICKS(`REL_0P1875_US) * TICK;
    localparam int DLY_STRAP = `TICKS(`DLY_7P5_US) * TICK;
    logic sys_clk;
    logic rst;
    logic press_a, press_b, press_single, strap_level;
    reset_timer_pkg::trig_t keys;
    reset_timer_pkg::trig_t single_keys;
    logic delay_sel;
    logic delay_sel_hi;
    logic strap_rst_n, fix_rst_n, single_rst_n;
    logic hi_rst_n;
    logic [31:0] pulse_len;
    int fail_count = 0;
    int checked = 0;
    int cyc = 0;
    int e0 = 0;
    key_host_model key_host_model_inst (.sys_clk(sys_clk), .press_a(press_a), .press_b(press_b),
        .press_single(press_single), .strap_level(strap_level), .keys(keys), .single_keys(single_keys),
        .delay_sel(delay_sel), .delay_sel_hi(delay_sel_hi), .host_rst_n(fix_rst_n), .pulse_len(pulse_len));
    long_press_reset_timer #(.STRAP_VARIANT(1'b1), .FIXED_CFG(`CFG_7P5_234), .TICK_CYCLES(TICK))
        long_press_reset_timer_hi_inst (.sys_clk(sys_clk), .rst(rst), .trigger_in_a_n(keys.a_n),
        .trigger_in_b_n(keys.b_n), .delay_sel(delay_sel_hi), .reset_out_n(hi_rst_n));
    long_press_reset_timer #(.STRAP_VARIANT(1'b1), .FIXED_CFG(`CFG_7P5_234), .TICK_CYCLES(TICK))
        long_press_reset_timer_inst (.sys_clk(sys_clk), .rst(rst), .trigger_in_a_n(keys.a_n),
        .trigger_in_b_n(keys.b_n), .delay_sel(delay_sel), .reset_out_n(strap_rst_n));
    long_press_reset_timer #(.STRAP_VARIANT(1'b0), .FIXED_CFG(`CFG_3P0_1875), .TICK_CYCLES(TICK))
        long_press_reset_timer_fix_inst (.sys_clk(sys_clk), .rst(rst), .trigger_in_a_n(keys.a_n),
        .trigger_in_b_n(keys.b_n), .delay_sel(delay_sel), .reset_out_n(fix_rst_n));
    long_press_reset_timer #(.STRAP_VARIANT(1'b0), .FIXED_CFG(`CFG_3P0_1875), .TICK_CYCLES(TICK))
        long_press_reset_timer_one_inst (.sys_clk(sys_clk), .rst(rst), .trigger_in_a_n(single_keys.a_n),
        .trigger_in_b_n(single_keys.b_n), .delay_sel(delay_sel), .reset_out_n(single_rst_n));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) cyc <= cyc + 1;
    task automatic at(input int k);
        while (cyc < e0 + k) @(negedge sys_clk);
    endtask : at
    task automatic press_all;
        press_a = 1'b1;
        press_b = 1'b1;
        press_single = 1'b1;
        e0 = cyc + 1;
    endtask : press_all
    task automatic scn_abort_restart;
        press_all();
        at(200);
        `CHK(fix_rst_n, 1'b1)
        `CHK(single_rst_n, 1'b1)
        press_a = 1'b0;
        press_single = 1'b0;
        @(negedge sys_clk);
        press_all();
    endtask : scn_abort_restart
    task automatic scn_fixed_delay;
        at(DLY_FIX - 1);
        `CHK(fix_rst_n, 1'b1)
        `CHK(single_rst_n, 1'b1)
        at(DLY_FIX);
        `CHK(fix_rst_n, 1'b0)
        `CHK(single_rst_n, 1'b0)
        at(DLY_FIX + 99);
        press_single = 1'b0;
        @(negedge sys_clk);
        `CHK(single_rst_n, 1'b1)
        at(DLY_FIX + REL_FIX - 1);
        `CHK(fix_rst_n, 1'b0)
        at(DLY_FIX + REL_FIX);
        `CHK(fix_rst_n, 1'b1)
    endtask : scn_fixed_delay
    task automatic scn_lockout_hold;
        // A wrongful restart after the automatic release would be low here.
        at(2 * DLY_FIX + REL_FIX + 5);
        `CHK(fix_rst_n, 1'b1)
        `CHK(pulse_len, 32'(REL_FIX))
        at(DLY_STRAP - 1);
        `CHK(strap_rst_n, 1'b1)
        at(DLY_STRAP);
        `CHK(strap_rst_n, 1'b0)
        `CHK(hi_rst_n, 1'b1)
        at(DLY_STRAP + 50);
        `CHK(strap_rst_n, 1'b0)
    endtask : scn_lockout_hold
    task automatic scn_release_repress;
        press_b = 1'b0;
        @(negedge sys_clk);
        `CHK(strap_rst_n, 1'b1)
        press_b = 1'b1;
        e0 = cyc + 1;
        at(DLY_FIX);
        `CHK(fix_rst_n, 1'b0)
    endtask : scn_release_repress
    task automatic end_sim;
        if (fail_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim
    initial begin
        rst = 1'b1;
        press_a = 1'b0;
        press_b = 1'b0;
        press_single = 1'b0;
        strap_level = 1'b0;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        repeat (2) @(negedge sys_clk);
        scn_abort_restart();
        scn_fixed_delay();
        scn_lockout_hold();
        scn_release_repress();
        end_sim();
    end
    initial begin
        repeat (DLY_STRAP + DLY_FIX + 2000) @(posedge sys_clk);
        fail_count++;
        end_sim();
    end
endmodule : long_press_reset_timer_tb

/* verilog/long_press_reset_timer.sv */
// Long-press reset timer driven by two active-low trigger inputs.
`timescale 1ns/1ns
`include "reset_timer_map.svh"
module long_press_reset_timer #(
    parameter bit STRAP_VARIANT = 1'b1,
    parameter logic [1:0] FIXED_CFG = `CFG_7P5_234,
    parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Key triggers, active low
    input wire logic trigger_in_a_n,
    input wire logic trigger_in_b_n,
    // Delay-select strap
    input wire logic delay_sel,
    // Reset toward the host, active low
    output logic reset_out_n
);
    reset_timer_pkg::state_t state_reg;
    reset_timer_pkg::state_t state_next;
    logic [`CNT_W-1:0] cnt_reg;
    logic [`CNT_W-1:0] cnt_next;
    logic strap_reg;
    logic strap_next;
    logic strap_taken_reg;
    logic reset_reg;
    logic reset_next;
    reset_timer_pkg::trig_t trig;
    reset_timer_pkg::timing_t timing;
    logic both_low;
    logic tick;
    logic restart;
    logic delay_done;
    logic release_done;

    // Delay and release lengths in timebase ticks for the chosen variant.
    function automatic reset_timer_pkg::timing_t pick_timing(input logic strap_var, input logic strap,
                                                             input logic [1:0] cfg);
        reset_timer_pkg::timing_t t;
        t.delay = `CNT_W'(`TICKS(`DLY_7P5_US));
        t.release_t = `CNT_W'(`TICKS(`REL_0P234_US));
        if (strap_var) begin
            if (strap) begin
                t.delay = `CNT_W'(`TICKS(`DLY_11P25_US));
            end
        end else begin
            case (cfg)
                `CFG_10_313: begin
                    t.delay = `CNT_W'(`TICKS(`DLY_10_US));
                    t.release_t = `CNT_W'(`TICKS(`REL_0P313_US));
                end
                `CFG_10_078: begin
                    t.delay = `CNT_W'(`TICKS(`DLY_10_US));
                    t.release_t = `CNT_W'(`TICKS(`REL_0P078_US));
                end
                `CFG_3P0_1875: begin
                    t.delay = `CNT_W'(`TICKS(`DLY_3P0_US));
                    t.release_t = `CNT_W'(`TICKS(`REL_0P1875_US));
                end
                default: begin
                    t.delay = `CNT_W'(`TICKS(`DLY_7P5_US));
                    t.release_t = `CNT_W'(`TICKS(`REL_0P234_US));
                end
            endcase
        end
        return t;
    endfunction : pick_timing

    assign trig = '{a_n: trigger_in_a_n, b_n: trigger_in_b_n};
    // A single-key board ties the other trigger low, so this AND still works.
    assign both_low = !trig.a_n && !trig.b_n;
    assign timing = pick_timing(STRAP_VARIANT, strap_reg, FIXED_CFG);

    // Counting restarts from zero on entry to the delay or the asserted phase.
    assign restart = state_reg != state_next;

    tick_divider #(
        .PERIOD(TICK_CYCLES)
    ) tick_divider_inst (
        .sys_clk(sys_clk),
        .rst(rst),
        .clr(restart),
        .tick(tick)
    );

    // The timebase gives delay*TICK_CYCLES cycles exactly, well inside ten percent.
    assign delay_done = tick && cnt_reg == timing.delay - `CNT_W'(1);
    assign release_done = tick && cnt_reg == timing.release_t - `CNT_W'(1);

    // The strap is caught once after reset; a later change cannot glitch the delay.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            strap_taken_reg <= 1'b0;
            strap_reg <= 1'b0;
        end else begin
            strap_taken_reg <= 1'b1;
            strap_reg <= strap_next;
        end
    end

    assign strap_next = strap_taken_reg ? strap_reg : delay_sel;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            reset_timer_pkg::ST_IDLE: begin
                if (both_low && strap_taken_reg) begin
                    state_next = reset_timer_pkg::ST_COUNT;
                end
            end
            reset_timer_pkg::ST_COUNT: begin
                if (!both_low) begin
                    state_next = reset_timer_pkg::ST_IDLE;
                end else if (delay_done) begin
                    state_next = reset_timer_pkg::ST_ASSERT;
                end
            end
            reset_timer_pkg::ST_ASSERT: begin
                if (!both_low) begin
                    state_next = reset_timer_pkg::ST_IDLE;
                end else if (!STRAP_VARIANT && release_done) begin
                    state_next = reset_timer_pkg::ST_LOCKOUT;
                end
            end
            default: begin
                if (!both_low) begin
                    state_next = reset_timer_pkg::ST_IDLE;
                end
            end
        endcase
    end

    always_comb begin
        if (restart) begin
            cnt_next = '0;
        end else if (tick) begin
            cnt_next = cnt_reg + `CNT_W'(1);
        end else begin
            cnt_next = cnt_reg;
        end
        reset_next = state_next == reset_timer_pkg::ST_ASSERT;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_reg <= reset_timer_pkg::ST_IDLE;
            cnt_reg <= '0;
            reset_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            reset_reg <= reset_next;
        end
    end

    assign reset_out_n = !reset_reg;

    sequence press_s;
        state_reg == reset_timer_pkg::ST_IDLE && both_low && strap_taken_reg;
    endsequence

    sequence counting_s;
        state_reg == reset_timer_pkg::ST_COUNT && cnt_reg == '0;
    endsequence

    start_count_a: assert property (@(posedge sys_clk) disable iff (rst)
        press_s |=> counting_s ##0 reset_out_n)
        else $error("count did not start on a double press");

    delay_assert_a: assert property (@(posedge sys_clk) disable iff (rst)
        (state_reg == reset_timer_pkg::ST_COUNT && delay_done && both_low) |=> !reset_out_n)
        else $error("reset not asserted when the delay elapsed");

    no_early_reset_a: assert property (@(posedge sys_clk) disable iff (rst)
        (state_reg == reset_timer_pkg::ST_COUNT && !delay_done) |=> reset_out_n)
        else $error("reset asserted before the delay elapsed");

    abort_count_a: assert property (@(posedge sys_clk) disable iff (rst)
        (state_reg == reset_timer_pkg::ST_COUNT && !both_low) |=> reset_out_n && cnt_reg == '0
        && state_reg == reset_timer_pkg::ST_IDLE)
        else $error("count not aborted on key release");

    strap_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        (STRAP_VARIANT && !reset_out_n && both_low) |=> !reset_out_n)
        else $error("strap variant dropped reset while keys held");

    key_release_a: assert property (@(posedge sys_clk) disable iff (rst)
        (!reset_out_n && !both_low) |=> reset_out_n)
        else $error("reset not released on key release");

    strap_delay_a: assert property (@(posedge sys_clk) disable iff (rst)
        (STRAP_VARIANT && strap_taken_reg) |-> timing.delay == (strap_reg
        ? `CNT_W'(`TICKS(`DLY_11P25_US)) : `CNT_W'(`TICKS(`DLY_7P5_US))))
        else $error("strap delay does not match the strap level");

    fixed_pair_a: assert property (@(posedge sys_clk) disable iff (rst)
        (!STRAP_VARIANT && FIXED_CFG == `CFG_3P0_1875) |-> timing.delay == `CNT_W'(`TICKS(`DLY_3P0_US))
        && timing.release_t == `CNT_W'(`TICKS(`REL_0P1875_US)))
        else $error("fixed delay and release pair wrong");

    auto_release_a: assert property (@(posedge sys_clk) disable iff (rst)
        (!STRAP_VARIANT && !reset_out_n && both_low && release_done)
        |=> reset_out_n && state_reg == reset_timer_pkg::ST_LOCKOUT)
        else $error("reset not released after the release time");

    lockout_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        (state_reg == reset_timer_pkg::ST_LOCKOUT && both_low) |=> reset_out_n
        && state_reg == reset_timer_pkg::ST_LOCKOUT)
        else $error("new count started without a key release");
endmodule : long_press_reset_timer

/* verilog/tick_divider.sv */
// Divider that turns the system clock into a one-cycle timebase tick.
`timescale 1ns/1ns
`include "reset_timer_map.svh"
module tick_divider #(
    parameter int unsigned PERIOD = `TICK_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Control and tick
    input wire logic clr,
    output logic tick
);
    localparam int W = $clog2(PERIOD + 1);
    localparam logic [W-1:0] LAST = W'(PERIOD - 1);

    logic [W-1:0] div_reg;
    logic [W-1:0] div_next;

    // Restarting on clear gives every interval an exact whole number of periods.
    always_comb begin
        if (clr || div_reg == LAST) begin
            div_next = '0;
        end else begin
            div_next = div_reg + W'(1);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_next;
        end
    end

    // The tick ignores the clear, so the clear raised by a tick-driven state change cannot loop back into the tick.
    assign tick = div_reg == LAST;

    tick_spacing_a: assert property (@(posedge sys_clk) disable iff (rst)
        (tick && PERIOD > 8) |=> !tick [*7])
        else $error("timebase tick came too early");
endmodule : tick_divider
